// file: rtl/hibctl_map.svh
// Register offsets, field positions and timing counts of the hibernation controller
`ifndef HIBCTL_MAP_SVH
`define HIBCTL_MAP_SVH
// ==========================================================
// Register byte offsets
`define HIB_A_CTL    8'h00
`define HIB_A_RTC    8'h04
`define HIB_A_MATCH  8'h08
`define HIB_A_SS     8'h0c
`define HIB_A_SSM    8'h10
`define HIB_A_TRIM   8'h14
`define HIB_A_WAKE   8'h18
`define HIB_A_IEN    8'h1c
`define HIB_A_IRAW   8'h20
`define HIB_A_IMSK   8'h24
`define HIB_A_STAT   8'h28
`define HIB_A_TCFG   8'h2c
`define HIB_A_TCLR   8'h30
`define HIB_A_LOG    3'b010
`define HIB_A_MEM    2'b10
// ==========================================================
// Control fields
`define HIB_C_EN     0
`define HIB_C_RTCEN  1
`define HIB_C_CAL    2
`define HIB_C_HIB    3
`define HIB_C_ABORT  4
`define HIB_C_XOSC   5
`define HIB_C_BATGO  6
`define HIB_C_RECOV  7
// Wake enable fields
`define HIB_W_PIN    0
`define HIB_W_RTC    1
`define HIB_W_BAT    2
`define HIB_W_GPIO   3
`define HIB_W_RST    4
`define HIB_W_TAMP   5
// Interrupt source fields
`define HIB_I_RTC    0
`define HIB_I_BAT    1
`define HIB_I_PIN    2
`define HIB_I_SS     3
`define HIB_I_TAMP   4
`define HIB_I_REFUSE 5
// Tamper configuration fields
`define HIB_T_EN     0
`define HIB_T_ERASE  5
`define HIB_T_PART   6
`define HIB_T_WAKE   7
// ==========================================================
// Reset values and timing
`define HIB_TRIM_RST 15'h7fff
`define HIB_CAL_ANY  8'hff
`define HIB_CLK_NS   10
`define HIB_SS_NS    30517
`define HIB_SS_CYC   (`HIB_SS_NS / `HIB_CLK_NS)
`define HIB_BAT_NS   2000
`define HIB_BAT_CYC  ((`HIB_BAT_NS + `HIB_CLK_NS - 1) / `HIB_CLK_NS)
`endif

// file: rtl/hibctl_pkg.sv
// Types shared by the hibernation controller modules
package hibctl_pkg;
  typedef enum logic [1:0] {
    HIB_AWAKE = 2'b00,
    HIB_HOLD  = 2'b01,
    HIB_SLEEP = 2'b10
  } hibctl_pwr_t;
endpackage

// file: rtl/hibctl_rtc_if.sv
// Interface between the controller core and its real-time counter
`timescale 1ns/1ps
interface hibctl_rtc_if;
  logic        run;
  logic        cal;
  logic        wr_val;
  logic        wr_match;
  logic        wr_ssm;
  logic        wr_trim;
  logic [31:0] wdata;
  logic [31:0] value;
  logic [31:0] match;
  logic [14:0] ss;
  logic [14:0] ssm;
  logic [14:0] trim;
  logic        hit;
  logic        ss_hit;
  modport rtc (input run, cal, wr_val, wr_match, wr_ssm, wr_trim, wdata,
               output value, match, ss, ssm, trim, hit, ss_hit);
  modport ctl (output run, cal, wr_val, wr_match, wr_ssm, wr_trim, wdata,
               input value, match, ss, ssm, trim, hit, ss_hit);
endinterface

// file: rtl/hibctl_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module hibctl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule

// file: rtl/hibctl_rtc.sv
// Seconds and subseconds counter with trim, match and calendar mode
`timescale 1ns/1ps
`include "hibctl_map.svh"
module hibctl_rtc #(
  parameter int SS_DIV = `HIB_SS_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  hibctl_rtc_if.rtc bus
);
  logic [15:0] pre_r;
  logic        eq_r;
  logic        sseq_r;
  logic        eq;
  logic        tick;

  // Calendar layout: day[31:24] hour[23:16] min[15:8] sec[7:0]
  function automatic logic [31:0] cal_inc(input logic [31:0] v);
    logic [31:0] r;
    r = v;
    if (v[7:0] < 8'h3b) begin
      r[7:0] = v[7:0] + 8'h01;
    end else begin
      r[7:0] = 8'h00;
      if (v[15:8] < 8'h3b) begin
        r[15:8] = v[15:8] + 8'h01;
      end else begin
        r[15:8] = 8'h00;
        if (v[23:16] < 8'h17) begin
          r[23:16] = v[23:16] + 8'h01;
        end else begin
          r[23:16] = 8'h00;
          r[31:24] = (v[31:24] < 8'h1f) ? v[31:24] + 8'h01 : 8'h01;
        end
      end
    end
    return r;
  endfunction

  always_comb begin
    eq = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (!(bus.cal && bus.match[8*i +: 8] == `HIB_CAL_ANY) &&
          bus.match[8*i +: 8] != bus.value[8*i +: 8]) begin
        eq = 1'b0;
      end
    end
  end

  assign tick = bus.run && (pre_r == 16'(SS_DIV - 1));

  // ==========================================================
  // Prescaler and counters
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_r <= 16'h0000;
    end else if (!bus.run || tick) begin
      pre_r <= 16'h0000;
    end else begin
      pre_r <= pre_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus.value <= 32'h0000_0000;
      bus.ss    <= 15'h0000;
    end else if (bus.wr_val) begin
      bus.value <= bus.wdata;
      bus.ss    <= 15'h0000;
    end else if (tick) begin
      // Trim sets the subsecond wrap point, so it scales the second length
      if (bus.ss >= bus.trim) begin
        bus.ss    <= 15'h0000;
        bus.value <= bus.cal ? cal_inc(bus.value) : bus.value + 32'h1;
      end else begin
        bus.ss <= bus.ss + 15'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus.match <= 32'hffff_ffff;
      bus.ssm   <= 15'h0000;
      bus.trim  <= `HIB_TRIM_RST;
    end else begin
      if (bus.wr_match) bus.match <= bus.wdata;
      if (bus.wr_ssm) bus.ssm <= bus.wdata[14:0];
      if (bus.wr_trim) bus.trim <= bus.wdata[14:0];
    end
  end

  // Match pulses fire once on entry to equality, not every cycle of it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      eq_r       <= 1'b1;
      sseq_r     <= 1'b1;
      bus.hit    <= 1'b0;
      bus.ss_hit <= 1'b0;
    end else begin
      eq_r       <= eq;
      sseq_r     <= bus.ss == bus.ssm;
      bus.hit    <= eq && !eq_r;
      bus.ss_hit <= (bus.ss == bus.ssm) && !sseq_r;
    end
  end
endmodule

// file: rtl/hibctl_top.sv
// Hibernation controller: RTC, wake sources, battery, tamper, backup memory
`timescale 1ns/1ps
`include "hibctl_map.svh"
module hibctl_top #(
  parameter int NTAMP   = 4,
  parameter int NGPIO   = 4,
  parameter int NMEM    = 16,
  parameter int NLOG    = 4,
  parameter int BAT_CYC = `HIB_BAT_CYC,
  parameter int SS_DIV  = `HIB_SS_CYC
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  // Register port
  input  wire logic [7:0]       addr_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [31:0]      rdata_o,
  // Pins and analog status
  input  wire logic             wake_pin_n_i,
  input  wire logic             rst_pin_n_i,
  input  wire logic [NGPIO-1:0] gpio_wake_i,
  input  wire logic [NTAMP-1:0] tamper_i,
  input  wire logic             osc_fail_i,
  input  wire logic             bat_low_i,
  // System outputs
  output logic                  pwr_en_o,
  output logic                  tamper_evt_o,
  output logic      [NTAMP-1:0] tamper_own_o,
  output logic                  bat_meas_o,
  output logic                  osc_recover_o,
  output logic                  irq_o
);
  localparam int NS = NTAMP + NGPIO + 4;

  logic                   rst_q1_r;
  logic                   rst_n;
  logic [NS-1:0]          pins_s;
  logic                   wake_s;
  logic                   rstp_s;
  logic                   osc_s;
  logic                   batl_s;
  logic [NGPIO-1:0]       gpio_s;
  logic [NTAMP-1:0]       tamp_s;
  logic [7:0]             ctl_r;
  logic [5:0]             wake_en_r;
  logic [5:0]             ien_r;
  logic [5:0]             iraw_r;
  logic [5:0]             iset;
  logic [7:0]             tcfg_r;
  logic [NTAMP-1:0]       tprev_r;
  logic [NTAMP-1:0]       tchg;
  logic                   osc_bad_r;
  logic                   osc_ev;
  logic                   tamp_ev;
  logic [15:0]            bat_cnt_r;
  logic                   lowbat_r;
  logic                   bat_done;
  logic [2:0]             log_cnt_r;
  logic [31:0]            log_rtc_r [NLOG];
  logic [NTAMP:0]         log_src_r [NLOG];
  logic [31:0]            mem_r [NMEM];
  logic                   wake_any;
  logic                   hib_go;
  logic                   refuse;
  logic [31:0]            rd_nxt;
  hibctl_pkg::hibctl_pwr_t pwr_r;
  hibctl_rtc_if           rtc_if ();

  // ==========================================================
  // Reset release and pin synchronisers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_q1_r <= 1'b1;
      rst_n    <= rst_q1_r;
    end
  end

  hibctl_sync #(.W(NS)) u_sync (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n),
    .d_i     ({tamper_i, gpio_wake_i, ~wake_pin_n_i, ~rst_pin_n_i, osc_fail_i, bat_low_i}),
    .q_o     (pins_s)
  );
  assign {tamp_s, gpio_s, wake_s, rstp_s, osc_s, batl_s} = pins_s;

  // ==========================================================
  // Real-time counter
  wire wr_rtc = wr_i && ctl_r[`HIB_C_EN];
  assign rtc_if.run      = ctl_r[`HIB_C_EN] && ctl_r[`HIB_C_RTCEN];
  assign rtc_if.cal      = ctl_r[`HIB_C_CAL];
  assign rtc_if.wdata    = wdata_i;
  assign rtc_if.wr_val   = wr_rtc && addr_i == `HIB_A_RTC;
  assign rtc_if.wr_match = wr_rtc && addr_i == `HIB_A_MATCH;
  assign rtc_if.wr_ssm   = wr_rtc && addr_i == `HIB_A_SSM;
  assign rtc_if.wr_trim  = wr_rtc && addr_i == `HIB_A_TRIM;

  hibctl_rtc #(.SS_DIV(SS_DIV)) u_rtc (
    .clk_i   (ref_clk_i),
    .rst_n_i (rst_n),
    .bus     (rtc_if.rtc)
  );

  // ==========================================================
  // Control and configuration registers
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r     <= 8'h00;
      wake_en_r <= 6'h00;
      ien_r     <= 6'h00;
      tcfg_r    <= 8'h00;
    end else begin
      // Command bits are one-cycle strobes, the rest hold
      ctl_r[`HIB_C_HIB]   <= 1'b0;
      ctl_r[`HIB_C_BATGO] <= 1'b0;
      ctl_r[`HIB_C_RECOV] <= 1'b0;
      if (wr_i) begin
        unique case (addr_i)
          `HIB_A_CTL:  ctl_r <= wdata_i[7:0];
          `HIB_A_WAKE: wake_en_r <= wdata_i[5:0];
          `HIB_A_IEN:  ien_r <= wdata_i[5:0];
          `HIB_A_TCFG: tcfg_r <= wdata_i[7:0];
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Battery check
  assign bat_done = bat_cnt_r == 16'h0001;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bat_cnt_r <= 16'h0000;
      lowbat_r  <= 1'b0;
    end else if (ctl_r[`HIB_C_BATGO] && bat_cnt_r == 16'h0000) begin
      bat_cnt_r <= 16'(BAT_CYC);
    end else if (bat_cnt_r != 16'h0000) begin
      bat_cnt_r <= bat_cnt_r - 16'h0001;
      if (bat_done) lowbat_r <= batl_s;
    end
  end

  // ==========================================================
  // Tamper detection, response and log
  assign tchg    = (tamp_s ^ tprev_r) & tcfg_r[NTAMP:1] & {NTAMP{tcfg_r[`HIB_T_EN]}};
  assign osc_ev  = tcfg_r[`HIB_T_EN] && ctl_r[`HIB_C_XOSC] && osc_s && !osc_bad_r;
  assign tamp_ev = (|tchg) || osc_ev;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tprev_r       <= '0;
      osc_bad_r     <= 1'b0;
      tamper_evt_o  <= 1'b0;
      tamper_own_o  <= '0;
      osc_recover_o <= 1'b0;
    end else begin
      tprev_r       <= tamp_s;
      tamper_evt_o  <= tamp_ev;
      tamper_own_o  <= tcfg_r[NTAMP:1] & {NTAMP{tcfg_r[`HIB_T_EN]}};
      osc_recover_o <= ctl_r[`HIB_C_RECOV] && osc_bad_r;
      // An osc_ev in the recovery cycle sets the flag; it wins over the clearing strobe
      if (osc_ev) osc_bad_r <= 1'b1;
      else if (ctl_r[`HIB_C_RECOV]) osc_bad_r <= 1'b0;
    end
  end

  // A full log keeps the oldest entries; later events are not stamped
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      log_cnt_r <= 3'h0;
      for (int i = 0; i < NLOG; i++) begin
        log_rtc_r[i] <= 32'h0000_0000;
        log_src_r[i] <= '0;
      end
    end else if (tamp_ev && log_cnt_r < 3'(NLOG)) begin
      log_rtc_r[log_cnt_r[1:0]] <= rtc_if.value;
      log_src_r[log_cnt_r[1:0]] <= {osc_ev, tchg};
      log_cnt_r <= log_cnt_r + 3'h1;
    end else if (wr_i && addr_i == `HIB_A_TCLR) begin
      log_cnt_r <= 3'h0;
    end
  end

  // ==========================================================
  // Battery-backed memory
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NMEM; i++) mem_r[i] <= 32'h0000_0000;
    end else if (tamp_ev && tcfg_r[`HIB_T_ERASE]) begin
      // Partial erase wipes only the upper half
      for (int i = 0; i < NMEM; i++) begin
        if (!tcfg_r[`HIB_T_PART] || i >= NMEM / 2) mem_r[i] <= 32'h0000_0000;
      end
    end else if (wr_i && addr_i[7:6] == `HIB_A_MEM) begin
      mem_r[addr_i[5:2]] <= wdata_i;
    end
  end

  // ==========================================================
  // Power sequencing and wake
  assign wake_any = (wake_en_r[`HIB_W_PIN] && wake_s) ||
                    (wake_en_r[`HIB_W_RTC] && rtc_if.hit) ||
                    (wake_en_r[`HIB_W_BAT] && lowbat_r) ||
                    (wake_en_r[`HIB_W_GPIO] && |gpio_s) ||
                    (wake_en_r[`HIB_W_RST] && rstp_s) ||
                    ((wake_en_r[`HIB_W_TAMP] || tcfg_r[`HIB_T_WAKE]) && tamp_ev);
  assign refuse = ctl_r[`HIB_C_ABORT] && lowbat_r;
  assign hib_go = pwr_r == hibctl_pkg::HIB_HOLD && bat_cnt_r == 16'h0000;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pwr_r    <= hibctl_pkg::HIB_AWAKE;
      pwr_en_o <= 1'b1;
    end else begin
      unique case (pwr_r)
        hibctl_pkg::HIB_AWAKE: begin
          if (ctl_r[`HIB_C_HIB] && ctl_r[`HIB_C_EN]) pwr_r <= hibctl_pkg::HIB_HOLD;
        end
        hibctl_pkg::HIB_HOLD: begin
          if (hib_go) begin
            pwr_r    <= refuse ? hibctl_pkg::HIB_AWAKE : hibctl_pkg::HIB_SLEEP;
            pwr_en_o <= refuse;
          end
        end
        hibctl_pkg::HIB_SLEEP: begin
          if (wake_any) begin
            pwr_r    <= hibctl_pkg::HIB_AWAKE;
            pwr_en_o <= 1'b1;
          end
        end
        default: begin
          pwr_r    <= hibctl_pkg::HIB_AWAKE;
          pwr_en_o <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Interrupt status
  always_comb begin
    iset = 6'h00;
    iset[`HIB_I_RTC]    = rtc_if.hit;
    iset[`HIB_I_BAT]    = bat_done && batl_s;
    iset[`HIB_I_PIN]    = pwr_r == hibctl_pkg::HIB_SLEEP && wake_s && wake_en_r[`HIB_W_PIN];
    iset[`HIB_I_SS]     = rtc_if.ss_hit;
    iset[`HIB_I_TAMP]   = tamp_ev;
    iset[`HIB_I_REFUSE] = hib_go && refuse;
  end

  // New events win over a write-one clear in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      iraw_r <= 6'h00;
      irq_o  <= 1'b0;
    end else begin
      if (wr_i && addr_i == `HIB_A_IRAW) begin
        iraw_r <= (iraw_r & ~wdata_i[5:0]) | iset;
      end else begin
        iraw_r <= iraw_r | iset;
      end
      irq_o <= |(iraw_r & ien_r);
    end
  end

  // ==========================================================
  // Register read
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (addr_i[7:5] == `HIB_A_LOG) begin
      if (addr_i[4:3] < log_cnt_r[1:0] || log_cnt_r == 3'(NLOG)) begin
        rd_nxt = addr_i[2] ? 32'(log_src_r[addr_i[4:3]]) : log_rtc_r[addr_i[4:3]];
      end
    end else if (addr_i[7:6] == `HIB_A_MEM) begin
      rd_nxt = mem_r[addr_i[5:2]];
    end else begin
      unique case (addr_i)
        `HIB_A_CTL:   rd_nxt = {24'h0, ctl_r};
        `HIB_A_RTC:   rd_nxt = rtc_if.value;
        `HIB_A_MATCH: rd_nxt = rtc_if.match;
        `HIB_A_SS:    rd_nxt = {17'h0, rtc_if.ss};
        `HIB_A_SSM:   rd_nxt = {17'h0, rtc_if.ssm};
        `HIB_A_TRIM:  rd_nxt = {17'h0, rtc_if.trim};
        `HIB_A_WAKE:  rd_nxt = {26'h0, wake_en_r};
        `HIB_A_IEN:   rd_nxt = {26'h0, ien_r};
        `HIB_A_IRAW:  rd_nxt = {26'h0, iraw_r};
        `HIB_A_IMSK:  rd_nxt = {26'h0, iraw_r & ien_r};
        `HIB_A_TCFG:  rd_nxt = {24'h0, tcfg_r};
        `HIB_A_STAT:  rd_nxt = {23'h0, pwr_r, log_cnt_r, lowbat_r,
                                bat_cnt_r != 16'h0000, !osc_bad_r,
                                ctl_r[`HIB_C_EN]};
        default:      rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o    <= 32'h0000_0000;
      bat_meas_o <= 1'b0;
    end else begin
      rdata_o    <= rd_i ? rd_nxt : 32'h0000_0000;
      bat_meas_o <= bat_cnt_r != 16'h0000;
    end
  end
endmodule

// file: testbench/hibctl_top_properties.sv
// Port-level checks for the hibernation controller
`timescale 1ns/1ps
module hibctl_top_properties #(
  parameter int NTAMP   = 4,
  parameter int NGPIO   = 4,
  parameter int BAT_CYC = 200
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  // Register port
  input  wire logic [7:0]       addr_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  input  wire logic [31:0]      rdata_o,
  // Pins
  input  wire logic             wake_pin_n_i,
  input  wire logic             rst_pin_n_i,
  input  wire logic [NGPIO-1:0] gpio_wake_i,
  input  wire logic [NTAMP-1:0] tamper_i,
  input  wire logic             osc_fail_i,
  input  wire logic             bat_low_i,
  // System outputs
  input  wire logic             pwr_en_o,
  input  wire logic             tamper_evt_o,
  input  wire logic [NTAMP-1:0] tamper_own_o,
  input  wire logic             bat_meas_o,
  input  wire logic             osc_recover_o,
  input  wire logic             irq_o
);
  logic bat_go;
  logic osc_go;
  logic own_wr;
  int   bat_cnt_r;
  assign bat_go = wr_i && addr_i == 8'h00 && wdata_i[6];
  assign osc_go = wr_i && addr_i == 8'h00 && wdata_i[7];
  assign own_wr = wr_i && addr_i == 8'h2c;
  // ==========================================================
  // Length of the busy window, counted outside the properties
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bat_cnt_r <= 0;
    end else if (bat_meas_o) begin
      bat_cnt_r <= bat_cnt_r + 1;
    end else begin
      bat_cnt_r <= 0;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // Assertions
  chk_rdata_idle: assert property (
    !$past(rd_i) |-> rdata_o == 32'h0) else $error("read data outside read slot");
  chk_reset_power: assert property (
    $rose(rst_n_i) |-> pwr_en_o) else $error("power off right after reset");
  chk_bat_cause: assert property (
    $rose(bat_meas_o) |-> $past(bat_go) || $past(bat_go, 2) || $past(bat_go, 3))
    else $error("battery check without start");
  chk_bat_length: assert property (
    $fell(bat_meas_o) |-> bat_cnt_r == BAT_CYC) else $error("battery check length");
  chk_hib_held: assert property (
    $fell(pwr_en_o) |-> !bat_meas_o) else $error("power dropped during check");
  chk_osc_pulse: assert property (
    osc_recover_o |=> !osc_recover_o) else $error("recovery pulse too long");
  chk_osc_cause: assert property (
    osc_recover_o |-> $past(osc_go) || $past(osc_go, 2) || $past(osc_go, 3))
    else $error("recovery without request");
  chk_tamper_seen: assert property (
    (|((tamper_i ^ $past(tamper_i)) & tamper_own_o)) && $stable(tamper_own_o)
    |-> ##[1:6] tamper_evt_o) else $error("tamper edge not indicated");
  chk_own_cause: assert property (
    $changed(tamper_own_o) |-> $past(own_wr) || $past(own_wr, 2))
    else $error("pin takeover without config write");
  cover property ($fell(bat_meas_o));
  cover property ($fell(pwr_en_o));
  cover property (tamper_evt_o);
endmodule

bind hibctl_top hibctl_top_properties #(
  .NTAMP(NTAMP), .NGPIO(NGPIO), .BAT_CYC(BAT_CYC)) u_props (.*);

// file: testbench/hibctl_env_model.sv
// Battery comparator and wake button beside the hibernation controller
`timescale 1ns/1ps
module hibctl_env_model (
  // Clock and controls
  input  wire logic clk_i,
  input  wire logic bat_meas_i,
  input  wire logic bat_is_low_i,
  input  wire logic wake_req_i,
  // Pins towards the block
  output logic      bat_low_o,
  output logic      wake_pin_n_o
);
  logic [2:0] hold_r = 3'h0;
  // Comparator is only valid while measuring; outside it shows the opposite
  // so a sample taken at the wrong moment gives the wrong answer
  assign bat_low_o = bat_meas_i ? bat_is_low_i : !bat_is_low_i;
  // Button held low several cycles so the pin synchroniser sees it
  always_ff @(posedge clk_i) begin
    if (wake_req_i) begin
      hold_r <= 3'h4;
    end else if (hold_r != 3'h0) begin
      hold_r <= hold_r - 3'h1;
    end
  end
  assign wake_pin_n_o = (hold_r == 3'h0);
endmodule

// file: testbench/tb.sv
// Register-level testbench of the hibernation controller
`timescale 1ns/1ps
module tb;
  logic ref_clk_i, rst_n_i, wr_i, rd_i, wake_pin_n_i, rst_pin_n_i;
  logic osc_fail_i, bat_low_i, pwr_en_o, tamper_evt_o, bat_meas_o;
  logic osc_recover_o, irq_o, bat_is_low, wake_req;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [3:0]  gpio_wake_i, tamper_i, tamper_own_o;
  int          err_total, checked, i;
  logic [7:0]  ra [5] = '{8'h04, 8'h08, 8'h10, 8'h14, 8'h18};
  logic [31:0] rv [5] = '{32'h100, 32'h200, 32'h1234, 32'h7ff0, 32'h3f};
  hibctl_top #(.BAT_CYC(20), .SS_DIV(4)) uut (.*);
  hibctl_env_model u_env (.clk_i(ref_clk_i), .bat_meas_i(bat_meas_o),
    .bat_is_low_i(bat_is_low), .wake_req_i(wake_req), .bat_low_o(bat_low_i),
    .wake_pin_n_o(wake_pin_n_i));
  always #5 ref_clk_i = ~ref_clk_i;
  // ==========================================================
  // Access and check tasks
  task end_of_test;
    $display("checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o & m, e);
  endtask
  // Bounded wait on an output level
  task automatic wt(ref logic s, input logic v);
    int n;
    for (n = 0; n < 400 && s !== v; n++) begin
      @(posedge ref_clk_i);
      #1;
    end
    checked++;
    if (s !== v) begin
      err_total++;
      $display("wrong value at %0t: wait ran out", $time);
      end_of_test();
    end
  endtask
  task te(input string nm);
    $display("test %0s done", nm);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    ref_clk_i = 0; rst_n_i = 0; addr_i = 0; wdata_i = 0; wr_i = 0; rd_i = 0;
    rst_pin_n_i = 1; gpio_wake_i = 0; tamper_i = 0; osc_fail_i = 0;
    bat_is_low = 0; wake_req = 0; err_total = 0; checked = 0;
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rd(8'h08, 32'hffffffff);
    rd(8'h14, 32'h7fff);
    rd(8'h28, 32'h0, 32'h1);
    wr(8'h00, 32'h1);
    rd(8'h28, 32'h3, 32'h3);
    for (i = 0; i < 5; i++) wr(ra[i], rv[i]);
    for (i = 0; i < 5; i++) rd(ra[i], rv[i]);
    for (i = 0; i < 16; i++) wr(8'h80 + 8'(4 * i), 32'hc0de0000 + 32'(i));
    for (i = 0; i < 16; i++) rd(8'h80 + 8'(4 * i), 32'hc0de0000 + 32'(i));
    rd(8'hc0, 32'h0);
    te("registers");
    wr(8'h1c, 32'h20);
    bat_is_low <= 1'b1;
    wr(8'h00, 32'h51);
    wt(bat_meas_o, 1'b1);
    wt(bat_meas_o, 1'b0);
    rd(8'h28, 32'h8, 32'hc);
    rd(8'h20, 32'h2);
    wr(8'h00, 32'h19);
    repeat (6) @(posedge ref_clk_i);
    chk(32'(pwr_en_o), 32'h1);
    rd(8'h20, 32'h22);
    rd(8'h24, 32'h20);
    chk(32'(irq_o), 32'h1);
    wr(8'h20, 32'h3f);
    rd(8'h20, 32'h0);
    chk(32'(irq_o), 32'h0);
    te("low battery");
    bat_is_low <= 1'b0;
    wr(8'h00, 32'h41);
    for (i = 0; i < 3; i++) begin
      wr(8'h00, 32'h09);
      if (i == 0) #1 chk(32'({pwr_en_o, bat_meas_o}), 32'h3);
      wt(pwr_en_o, 1'b0);
      wake_req <= (i == 0);
      gpio_wake_i <= (i == 1) ? 4'h2 : 4'h0;
      rst_pin_n_i <= (i != 2);
      @(posedge ref_clk_i);
      wake_req <= 1'b0;
      wt(pwr_en_o, 1'b1);
      gpio_wake_i <= 4'h0;
      rst_pin_n_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
    end
    te("wake");
    wr(8'h80, 32'ha5);
    wr(8'h2c, 32'h23);
    repeat (2) @(posedge ref_clk_i);
    chk(32'(tamper_own_o), 32'h1);
    tamper_i <= 4'h1;
    wt(tamper_evt_o, 1'b1);
    repeat (2) @(posedge ref_clk_i);
    rd(8'h80, 32'h0);
    rd(8'h28, 32'h10, 32'h70);
    rd(8'h44, 32'h1);
    rd(8'h40, 32'h100);
    wr(8'h30, 32'h0);
    rd(8'h28, 32'h0, 32'h70);
    te("tamper");
    // Settle time for a crystal before the source is chosen
    repeat (8) @(posedge ref_clk_i);
    wr(8'h00, 32'h21);
    osc_fail_i <= 1'b1;
    wt(tamper_evt_o, 1'b1);
    rd(8'h28, 32'h0, 32'h2);
    osc_fail_i <= 1'b0;
    wr(8'h00, 32'ha1);
    wt(osc_recover_o, 1'b1);
    te("oscillator");
    wr(8'h14, 32'h1);
    wr(8'h04, 32'h3b);
    wr(8'h08, 32'hffffff00);
    wr(8'h10, 32'h1);
    wr(8'h20, 32'h3f);
    // Calendar run: second 59 rolls into minute 1 after two ticks of trim 1
    wr(8'h00, 32'h07);
    repeat (8) @(posedge ref_clk_i);
    wr(8'h00, 32'h01);
    rd(8'h20, 32'h9, 32'h9);
    rd(8'h04, 32'h100);
    rd(8'h0c, 32'h0);
    te("calendar");
    end_of_test();
  end
endmodule
